// *** shared/strap_pkg.sv ***
// Constants for the reset strap loader and interrupt pass-through.
// Assumes a single clock domain; pins are synchronised before use.
// Summary of operation
// - Capture straps when PCI and local resets release.
// - Burst high, size1 low selects processor master.
// - EEPROM loads only if data and enable high.
// - Test selects low normally; 01 and 10 select test modes, 11 runs normally.
// - Master strap high during PCI reset sets bus-master.
// - Arbiter enabled only if strap high at release.
// - Bus-off strap forces target retry until software clears.
// - Host use: PCI interrupt drives local interrupt out.
// - Never drive autovector or transfer ack in acknowledge.
// - Adapter use: local interrupt forwarded to PCI interrupt.
// - Data strobe and DMA request outputs have no function.
// - Config select tied low: ignore configuration cycles.
// - Image select picks slave image under window select.
package strap_pkg;
   // Positions inside the synchronised pin vector
   localparam int SYNC_W       = 14;
   localparam int IX_PCIRST    = 0;
   localparam int IX_LOCRST    = 1;
   localparam int IX_BURST     = 2;
   localparam int IX_SIZE1     = 3;
   localparam int IX_SDATA     = 4;
   localparam int IX_EEPEN     = 5;
   localparam int IX_MSTEN     = 6;
   localparam int IX_ARBEN     = 7;
   localparam int IX_BUSOFF    = 8;
   localparam int IX_TEST0     = 9;
   localparam int IX_TEST1     = 10;
   localparam int IX_PCIINT    = 11;
   localparam int IX_LOCIRQ    = 12;
   localparam int IX_CFGSEL    = 13;
   // Values after reset
   // Both resets read as asserted, so no false release follows nrst
   localparam logic [13:0] SYNC_RST = 14'h1800;
   localparam logic        BIT_RST  = 1'h0;
   localparam int          TEST_W   = 2;
   // Test select encodings
   localparam logic [1:0]  TEST_NORMAL = 2'h0;
   localparam logic [1:0]  TEST_TRI    = 2'h1;
   localparam logic [1:0]  TEST_NAND   = 2'h2;
   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_TRISTATE,
      MODE_NANDTREE
   } test_mode_t;
endpackage

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for a vector of independent level pins.
// Assumes each bit is a slow level; no multi-bit coherence is given.
`timescale 1ns/1ps
module pin_sync #(
   parameter int                 WIDTH = 1,
   parameter logic [WIDTH-1:0]   INIT  = '0
) (
   input  wire logic             clk,   // Core clock
   input  wire logic             nrst,  // Async reset, active low
   input  wire logic             ce,    // Clock enable
   input  wire logic [WIDTH-1:0] din,   // Asynchronous pins
   output logic      [WIDTH-1:0] dout   // Synchronised levels
);
   logic [WIDTH-1:0] stage1;

   if (WIDTH < 1) begin : g_width_check
      $error("pin_sync needs WIDTH >= 1");
   end

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= INIT;
         dout   <= INIT;
      end else if (ce) begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule

// *** rtl/bridge_reset_strap_and_irq_pass.sv ***
// Reset strap loader, host-bus access gating and interrupt pass-through.
// Assumes local bus signals share clk; straps and interrupts are async.
`timescale 1ns/1ps
module bridge_reset_strap_and_irq_pass (
   input  wire logic clk,                 // Core clock, 250 MHz
   input  wire logic nrst,                // Async reset, active low
   input  wire logic ce,                  // Clock enable
   input  wire logic pciResetN,           // PCI reset pin, active low
   input  wire logic localResetInN,       // Local reset pin, active low
   input  wire logic burstProgressStrap,  // Strap pin
   input  wire logic sizeBit1Strap,       // Strap pin
   input  wire logic serialDataStrap,     // Strap pin
   input  wire logic eepromEnableStrap,   // Strap pin
   input  wire logic [strap_pkg::TEST_W-1:0] testSelectStrap, // Test pins
   input  wire logic masterEnableStrap,   // Strap pin
   input  wire logic internalArbiterStrap, // Strap pin
   input  wire logic hostBusOffStrap,     // Strap pin
   input  wire logic hostBridgeUse,       // 1 host, 0 adapter card
   input  wire logic swSetBusMaster,      // Software sets bus-master
   input  wire logic swClearBusMaster,    // Software clears bus-master
   input  wire logic swClearBusOff,       // Software clears bus-off
   input  wire logic targetAccess,        // PCI target access pulse
   input  wire logic configCycle,         // PCI config cycle pulse
   input  wire logic configSelectPin,     // PCI config select pin
   input  wire logic intAckCycle,         // Interrupt acknowledge cycle
   input  wire logic bridgeWindowChipSelN, // Window select, active low
   input  wire logic slaveImageSelect,    // Image select
   input  wire logic pciIntInN,           // PCI interrupt pin input
   input  wire logic localIrqInN,         // Local interrupt pin input
   output logic      pciIntOut,           // PCI interrupt pin output
   output logic      pciIntOe,            // PCI interrupt pin enable
   output logic      localIrqOut,         // Local interrupt output
   output logic      localIrqOe,          // Local interrupt enable
   output logic      autovectorAckOe,     // Autovector ack enable
   output logic      transferAckOe,       // Transfer ack enable in IACK
   output logic      dataStrobeOutN,      // Unused strobe, held high
   output logic      dmaRequestOutN,      // Unused request, held high
   output logic      procMasterMode,      // Processor master mode
   output logic      eepromLoadEn,        // EEPROM load enabled
   output strap_pkg::test_mode_t testMode, // Test mode
   output logic      busMasterBit,        // Command bus-master bit
   output logic      internalArbiterEn,   // Internal arbiter on
   output logic      hostBusOff,          // Bus-off status bit
   output logic      targetRetry,         // Retry this target access
   output logic      configAccept,        // Claim config cycle
   output logic      image0Hit,           // Slave image 0 selected
   output logic      image1Hit            // Slave image 1 selected
);
   import strap_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------
   logic [SYNC_W-1:0] pinRaw;
   logic [SYNC_W-1:0] pinSync;

   assign pinRaw = {configSelectPin, localIrqInN, pciIntInN,
                    testSelectStrap, hostBusOffStrap,
                    internalArbiterStrap, masterEnableStrap,
                    eepromEnableStrap, serialDataStrap, sizeBit1Strap,
                    burstProgressStrap, localResetInN, pciResetN};

   pin_sync #(
      .WIDTH (SYNC_W),
      .INIT  (SYNC_RST)
   ) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .ce   (ce),
      .din  (pinRaw),
      .dout (pinSync)
   );

   // ------------------------------------------------------------
   // Reset event decode
   // ------------------------------------------------------------
   wire pciRstActive = !pinSync[IX_PCIRST];
   wire anyRstActive = !pinSync[IX_PCIRST] || !pinSync[IX_LOCRST];
   logic rstSeen;
   // Release only once both resets are high again
   wire rstRelease   = rstSeen && !anyRstActive;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstSeen <= 1'h1;
      end else if (ce) begin
         rstSeen <= anyRstActive;
      end
   end

   // ------------------------------------------------------------
   // Strap decode and capture
   // ------------------------------------------------------------
   wire next_procMaster = pinSync[IX_BURST] && !pinSync[IX_SIZE1];
   wire next_eepromLoad = pinSync[IX_SDATA] && pinSync[IX_EEPEN];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         procMasterMode    <= BIT_RST;
         eepromLoadEn      <= BIT_RST;
         internalArbiterEn <= BIT_RST;
      end else if (ce && rstRelease) begin
         procMasterMode    <= next_procMaster;
         eepromLoadEn      <= next_eepromLoad;
         internalArbiterEn <= pinSync[IX_ARBEN];
      end
   end

   // Bus-off: strap sets at release; a clear loses to that set
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hostBusOff <= BIT_RST;
      end else if (ce) begin
         if (rstRelease) begin
            hostBusOff <= pinSync[IX_BUSOFF];
         end else if (swClearBusOff) begin
            hostBusOff <= 1'h0;
         end
      end
   end

   // Bus-master bit follows the strap for the whole PCI reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busMasterBit <= BIT_RST;
      end else if (ce) begin
         if (pciRstActive) begin
            busMasterBit <= pinSync[IX_MSTEN];
         end else if (swSetBusMaster) begin
            busMasterBit <= 1'h1;
         end else if (swClearBusMaster) begin
            busMasterBit <= 1'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // Test mode select
   // ------------------------------------------------------------
   wire [1:0] testSel = {pinSync[IX_TEST1], pinSync[IX_TEST0]};
   test_mode_t next_testMode;

   always_comb begin
      case (testSel)
         TEST_NORMAL: next_testMode = MODE_RUN;
         TEST_TRI:    next_testMode = MODE_TRISTATE;
         TEST_NAND:   next_testMode = MODE_NANDTREE;
         default:     next_testMode = MODE_RUN;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         testMode <= MODE_RUN;
      end else if (ce) begin
         testMode <= next_testMode;
      end
   end

   // Tester owns the pins in any test mode
   wire pinsLive = (testMode == MODE_RUN);

   // ------------------------------------------------------------
   // Access gating and image select
   // ------------------------------------------------------------
   assign targetRetry  = targetAccess && hostBusOff;
   assign configAccept = configCycle && pinSync[IX_CFGSEL];
   wire windowSel      = !bridgeWindowChipSelN;
   assign image0Hit    = windowSel && !slaveImageSelect;
   assign image1Hit    = windowSel && slaveImageSelect;

   // ------------------------------------------------------------
   // Interrupt pass-through (open drain, drive low to assert)
   // ------------------------------------------------------------
   wire pciIntAsserted   = !pinSync[IX_PCIINT];
   wire localIrqAsserted = !pinSync[IX_LOCIRQ];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         localIrqOe <= 1'h0;
         pciIntOe   <= 1'h0;
      end else if (ce) begin
         localIrqOe <= pinsLive && hostBridgeUse && pciIntAsserted;
         pciIntOe <= pinsLive && !hostBridgeUse && localIrqAsserted;
      end
   end

   assign localIrqOut = 1'h0;
   assign pciIntOut   = 1'h0;
   // Acknowledge cycle must be ended by outside logic
   assign autovectorAckOe = 1'h0;
   assign transferAckOe   = 1'h0;
   // No function in this mode; parked inactive
   assign dataStrobeOutN  = 1'h1;
   assign dmaRequestOutN  = 1'h1;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_strap_hold;
      @(posedge clk) disable iff (!nrst)
      (ce && !rstRelease) |=> $stable(procMasterMode) && $stable(eepromLoadEn)
         && $stable(internalArbiterEn);
   endproperty
   a_strap_hold: assert property (p_strap_hold)
      else $error("Captured strap changed without reset release");

   property p_proc_mode;
      @(posedge clk) disable iff (!nrst)
      (ce && rstRelease) |=> procMasterMode ==
         ($past(pinSync[IX_BURST]) && !$past(pinSync[IX_SIZE1]));
   endproperty
   a_proc_mode: assert property (p_proc_mode)
      else $error("Processor master mode decoded wrongly");

   property p_eeprom;
      @(posedge clk) disable iff (!nrst)
      (ce && rstRelease && !pinSync[IX_SDATA]) |=> !eepromLoadEn;
   endproperty
   a_eeprom: assert property (p_eeprom)
      else $error("EEPROM load enabled with data strap low");

   property p_arb;
      @(posedge clk) disable iff (!nrst)
      (ce && rstRelease) |=> internalArbiterEn == $past(pinSync[IX_ARBEN]);
   endproperty
   a_arb: assert property (p_arb)
      else $error("Arbiter enable not taken from strap");

   property p_bm;
      @(posedge clk) disable iff (!nrst)
      (ce && pciRstActive && pinSync[IX_MSTEN]) |=> busMasterBit;
   endproperty
   a_bm: assert property (p_bm)
      else $error("Bus-master bit not set by strap");

   property p_retry;
      @(posedge clk) disable iff (!nrst)
      hostBusOff && targetAccess |-> targetRetry;
   endproperty
   a_retry: assert property (p_retry)
      else $error("Target access not retried while bus off");

   property p_busoff_set_wins;
      @(posedge clk) disable iff (!nrst)
      (ce && rstRelease && pinSync[IX_BUSOFF]) |=> hostBusOff;
   endproperty
   a_busoff_set_wins: assert property (p_busoff_set_wins)
      else $error("Bus-off strap lost at reset release");

   property p_host_irq;
      @(posedge clk) disable iff (!nrst)
      (ce && pinsLive && hostBridgeUse && pciIntAsserted) |=> localIrqOe;
   endproperty
   a_host_irq: assert property (p_host_irq)
      else $error("PCI interrupt not passed to local side");

   property p_card_irq;
      @(posedge clk) disable iff (!nrst)
      (ce && !hostBridgeUse) |=> !localIrqOe;
   endproperty
   a_card_irq: assert property (p_card_irq)
      else $error("Local interrupt driven in adapter use");

   property p_no_ack;
      @(posedge clk) disable iff (!nrst)
      intAckCycle |-> !autovectorAckOe && !transferAckOe;
   endproperty
   a_no_ack: assert property (p_no_ack)
      else $error("Acknowledge driven in interrupt cycle");

   property p_cfg;
      @(posedge clk) disable iff (!nrst)
      !pinSync[IX_CFGSEL] |-> !configAccept;
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("Config cycle claimed with select low");

   property p_image;
      @(posedge clk) disable iff (!nrst)
      windowSel |-> (image1Hit == slaveImageSelect)
         && (image0Hit != image1Hit);
   endproperty
   a_image: assert property (p_image)
      else $error("Slave image select wrong");
endmodule

// *** sim/strap_far_side.sv ***
// Far-side model: board straps with pull resistors, open-drain INT wires.
// Assumes the bench drives requests at the rising edge of the core clock.
`timescale 1ns/1ps
module strap_far_side (
   input  wire logic       fitted,        // Board logic drives the straps
   input  wire logic [8:0] strapDrive,    // Driven strap levels
   input  wire logic       pciIntOe,      // Device pulls PCI INT low
   input  wire logic       localIrqOe,    // Device pulls local IRQ low
   input  wire logic       pciAgentInt,   // Other PCI agent asserts INT
   input  wire logic       localAgentIrq, // Local source asserts IRQ
   input  wire logic       intAckCycle,   // Acknowledge cycle running
   output logic      [8:0] strapPin,      // Levels at the strap pins
   output logic            pciIntN,       // Resolved PCI INT wire
   output logic            localIrqN,     // Resolved local IRQ wire
   output logic            extAckN,       // External cycle termination
   output logic      [3:0] transCode,     // Codes from type and modifier
   output logic      [4:0] parkedInN,     // Unused device inputs
   output logic            startWait      // Wait state on transfer start
);
   // ----------------------------------------
   // Straps: unfitted pins settle at their pull level
   // ----------------------------------------
   assign strapPin[0]   = fitted ? strapDrive[0] : 1'h1;
   assign strapPin[1]   = fitted ? strapDrive[1] : 1'h0;
   assign strapPin[3:2] = fitted ? strapDrive[3:2] : 2'h0;
   assign strapPin[6:4] = fitted ? strapDrive[6:4] : 3'h0;
   assign strapPin[8:7] = fitted ? strapDrive[8:7] : 2'h0;
   // ----------------------------------------
   // Wired-AND lines with pull-up, idle high
   // ----------------------------------------
   assign pciIntN   = ~(pciIntOe | pciAgentInt);
   assign localIrqN = ~(localIrqOe | localAgentIrq);
   // Device never ends the acknowledge cycle, so glue logic does
   assign extAckN   = ~intAckCycle;
   // ----------------------------------------
   // Processor-side lines kept at legal levels
   // ----------------------------------------
   // Four of the five type and modifier lines, idle in this model
   assign transCode = 4'h0;
   assign parkedInN = 5'h1f;
   // Slow decode assumed, so the start is always stretched
   assign startWait = 1'h1;
endmodule

// *** sim/bridge_reset_strap_and_irq_pass_bench.sv ***
// Self-checking bench for the strap loader and interrupt pass-through.
// Assumes strap_far_side stands at the pins; ce drops once to freeze state.
`timescale 1ns/1ps
module bridge_reset_strap_and_irq_pass_bench;
   import strap_pkg::*;
   logic       clk, nrst, ce, pciResetN, localResetInN, fitted, host;
   logic       swSet, swClr, swClrOff, tAcc, cfgCyc, cfgPin, iack;
   logic       csN, slave_image_select, pciAg, locAg;
   logic [8:0] drv;
   wire  [8:0] pin;
   wire        pciIntN, locIrqN, pciOut, pciOe, locOut, locOe, avOe, taOe;
   wire        dsN, drqN, procM, eepEn, bm, arbEn, busOff, retry, cfgAcc;
   wire        hit0, hit1;
   test_mode_t tMode;
   int         n_fail, n_checks, seed, r;

   strap_far_side i_far (.fitted(fitted), .strapDrive(drv),
      .pciIntOe(pciOe), .localIrqOe(locOe), .pciAgentInt(pciAg),
      .localAgentIrq(locAg), .intAckCycle(iack), .strapPin(pin),
      .pciIntN(pciIntN), .localIrqN(locIrqN), .extAckN(),
      .transCode(), .parkedInN(), .startWait());
   bridge_reset_strap_and_irq_pass i_dut (.clk(clk), .nrst(nrst), .ce(ce),
      .pciResetN(pciResetN), .localResetInN(localResetInN),
      .burstProgressStrap(pin[0]), .sizeBit1Strap(pin[1]),
      .serialDataStrap(pin[2]), .eepromEnableStrap(pin[3]),
      .testSelectStrap(pin[8:7]), .masterEnableStrap(pin[4]),
      .internalArbiterStrap(pin[5]), .hostBusOffStrap(pin[6]),
      .hostBridgeUse(host), .swSetBusMaster(swSet),
      .swClearBusMaster(swClr), .swClearBusOff(swClrOff),
      .targetAccess(tAcc), .configCycle(cfgCyc), .configSelectPin(cfgPin),
      .intAckCycle(iack), .bridgeWindowChipSelN(csN),
      .slaveImageSelect(slave_image_select), .pciIntInN(pciIntN), .localIrqInN(locIrqN),
      .pciIntOut(pciOut), .pciIntOe(pciOe), .localIrqOut(locOut),
      .localIrqOe(locOe), .autovectorAckOe(avOe), .transferAckOe(taOe),
      .dataStrobeOutN(dsN), .dmaRequestOutN(drqN), .procMasterMode(procM),
      .eepromLoadEn(eepEn), .testMode(tMode), .busMasterBit(bm),
      .internalArbiterEn(arbEn), .hostBusOff(busOff), .targetRetry(retry),
      .configAccept(cfgAcc), .image0Hit(hit0), .image1Hit(hit1));

   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   // ----------------------------------------
   // Checking and reference model
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_sample(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic cmp(input logic [8:0] s, input logic m);
      check(procM, s[0] & ~s[1]);
      check(eepEn, s[2] & s[3]);
      check(bm, m);
      check(arbEn, s[5]);
      check(busOff, s[6]);
   endtask

   // Straps a while PCI reset is low, b by the later local release
   task automatic boot(input logic [8:0] a, input logic [8:0] b);
      logic [8:0] eb;
      @(posedge clk);
      // Taken after the edge, once the caller's fitted change has landed
      eb = fitted ? b : 9'h001;
      pciResetN     <= 1'h0;
      localResetInN <= 1'h0;
      drv           <= a;
      repeat (4) @(posedge clk);
      pciResetN     <= 1'h1;
      repeat (4) @(posedge clk);
      drv           <= b;
      repeat (3) @(posedge clk);
      localResetInN <= 1'h1;
      wait_sample(6);
      cmp(eb, fitted & a[4]);
      @(posedge clk);
      r = $random(seed);
      drv <= r[8:0] & 9'h07f;
      wait_sample(6);
      cmp(eb, fitted & a[4]);
   endtask

   task automatic conclude();
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      conclude();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {nrst, pciResetN, localResetInN, host, swSet, swClr} = 6'h00;
      {swClrOff, tAcc, cfgCyc, cfgPin, iack, slave_image_select, pciAg, locAg} = 8'h00;
      csN = 1'h1;
      ce = 1'h1;
      fitted = 1'h1;
      drv = 9'h000;
      n_fail = 0;
      n_checks = 0;
      seed = 32'h117e_8927;
      repeat (5) @(posedge clk);
      nrst <= 1'h1;
      for (int i = 0; i < 9; i++) begin
         @(posedge clk);
         fitted <= (i != 8);
         r = $random(seed);
         boot(r[8:0] & 9'h07f, r[24:16] & 9'h07f);
      end
      @(posedge clk);
      fitted <= 1'h1;
      boot(9'h040, 9'h040);
      // Bus-off retries target accesses until software clears it
      @(posedge clk);
      tAcc <= 1'h1;
      wait_sample(1);
      check(retry, 1'h1);
      @(posedge clk);
      swClrOff <= 1'h1;
      @(posedge clk);
      swClrOff <= 1'h0;
      wait_sample(1);
      check(busOff, 1'h0);
      check(retry, 1'h0);
      // Strap left low: software must set the master bit
      @(posedge clk);
      tAcc  <= 1'h0;
      swSet <= 1'h1;
      @(posedge clk);
      swSet <= 1'h0;
      wait_sample(1);
      check(bm, 1'h1);
      @(posedge clk);
      swClr <= 1'h1;
      @(posedge clk);
      swClr     <= 1'h0;
      pciResetN <= 1'h0;
      wait_sample(4);
      check(bm, 1'h0);
      @(posedge clk);
      swSet <= 1'h1;
      @(posedge clk);
      swSet  <= 1'h0;
      drv[4] <= 1'h1;
      wait_sample(5);
      check(bm, 1'h1);
      @(posedge clk);
      pciResetN <= 1'h1;
      drv       <= 9'h000;
      // Test selects; interrupts are blocked outside run mode
      host  <= 1'h1;
      pciAg <= 1'h1;
      for (int t = 0; t < 4; t++) begin
         @(posedge clk);
         drv[8:7] <= t[1:0];
         wait_sample(6);
         check(tMode, t == 1 ? MODE_TRISTATE : t == 2 ? MODE_NANDTREE :
               MODE_RUN);
         check(locOe, t == 0 || t == 3);
      end
      @(posedge clk);
      drv[8:7] <= 2'h0;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         host  <= i[1];
         pciAg <= i[0];
         locAg <= i[0];
         iack  <= i[0];
         wait_sample(6);
         check(locOe, i == 3);
         check(pciOe, i == 1);
         check({pciOut, locOut}, 2'h0);
         check({avOe, taOe, dsN, drqN}, 4'h3);
      end
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         cfgPin <= p[0];
         repeat (4) @(posedge clk);
         cfgCyc <= 1'h1;
         wait_sample(1);
         check(cfgAcc, p[0]);
         @(posedge clk);
         cfgCyc <= 1'h0;
      end
      // Clock enable low freezes the synchroniser and test mode
      @(posedge clk);
      ce       <= 1'h0;
      drv[8:7] <= 2'h1;
      wait_sample(6);
      check(tMode, MODE_RUN);
      @(posedge clk);
      ce <= 1'h1;
      wait_sample(6);
      check(tMode, MODE_TRISTATE);
      @(posedge clk);
      drv[8:7] <= 2'h0;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         csN   <= i[1];
         slave_image_select <= i[0];
         wait_sample(1);
         check({hit1, hit0}, i == 0 ? 2'h1 : i == 1 ? 2'h2 : 2'h0);
      end
      conclude();
   end
endmodule
